// file: verilog/scu_pkg.sv
// Package for the shift and compare unit: register map, fields, reset values
// Assumes a 32-bit AHB-Lite register bus and 16-bit operands in the low bits

// ============================================================================
// Package
// ============================================================================
package scu_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_ACC    = 8'h00;   // Accumulator
    localparam logic [7:0] OFS_EXT    = 8'h04;   // Extended accumulator
    localparam logic [7:0] OFS_SHIFT  = 8'h08;   // Write effective instruction to shift
    localparam logic [7:0] OFS_CMP    = 8'h0c;   // Write effective word to compare
    localparam logic [7:0] OFS_FLAGS  = 8'h10;   // Overflow and carry indicators

    // Effective instruction fields, bit 15 of the word is instruction bit 0
    localparam int BIT_NORM   = 8;               // Instruction bit 7
    localparam int BIT_DOUBLE = 7;               // Instruction bit 8
    localparam int BIT_CIRC   = 6;               // Instruction bit 9
    localparam int BIT_LEFT   = 5;               // Instruction bit 10
    localparam int CNT_MSB    = 4;               // Instruction bits 11 to 15
    localparam int CNT_STEPS  = 32;              // Largest count plus one

    // Flags register fields
    localparam int FLG_CARRY  = 0;
    localparam int FLG_OVFL   = 1;

    // Reset values
    localparam logic [15:0] RST_ACC   = 16'h0000;
    localparam logic [15:0] RST_EXT   = 16'h0000;
    localparam logic        RST_FLAG  = 1'b0;

    // AHB constants
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic        HRESP_OKAY    = 1'b0;

    // Decoded shift operation
    typedef struct packed {
        logic       norm;
        logic       dbl;
        logic       circ;
        logic       left;
        logic [4:0] cnt;
    } scu_op_t;

    // Result of a shift or compare
    typedef struct packed {
        logic [15:0] ext;
        logic [15:0] acc;
        logic        ovfl;
        logic        carry;
    } scu_res_t;

endpackage : scu_pkg

// file: verilog/scu_top.sv
// Shift and compare datapath with its AHB-Lite register slave
// Assumes one AHB-Lite master on mclk; the slave is zero wait state, always OKAY
//
// Function
// - Instruction bits 7-10 select the operation
// - Five low bits give count 0-31
// - Arithmetic right single copies sign, drops bits
// - Right shifts clear overflow and carry
// - Double shifts join extended and accumulator
// - Arithmetic right double copies extended sign
// - Arithmetic left single zero fills right
// - Arithmetic left overflow when sign changed
// - Left shifts carry on odd sign ones
// - Arithmetic left double zero fills accumulator
// - Circular right single wraps low bit into sign bit
// - Circular right double rotates whole pair
// - Circular left single wraps sign bit
// - Circular left double rotates whole pair
// - Circular left always clears overflow
// - Compare is signed, operands unchanged
// - Compare flags less 00, greater 10, equal 11

`timescale 1ns/1ps
`default_nettype none

module scu_top (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Indicator outputs
    output logic             ovfl,
    output logic             carry
);

    // ========================================================================
    // Decode helpers
    // ========================================================================

    // Split the effective instruction into its fields
    function automatic scu_pkg::scu_op_t decode_op(input logic [15:0] ins);
        scu_pkg::scu_op_t op;
        op.norm = ins[scu_pkg::BIT_NORM];
        op.dbl  = ins[scu_pkg::BIT_DOUBLE];
        op.circ = ins[scu_pkg::BIT_CIRC];
        op.left = ins[scu_pkg::BIT_LEFT];
        op.cnt  = ins[scu_pkg::CNT_MSB:0];
        return op;
    endfunction : decode_op

    // Step the shift one position at a time; single shifts keep A in the top half
    function automatic scu_pkg::scu_res_t do_shift(input logic [15:0] e,
                                                   input logic [15:0] a,
                                                   input logic [15:0] ins);
        scu_pkg::scu_op_t  op;
        scu_pkg::scu_res_t r;
        logic [31:0]       v;
        logic              sgn;
        logic              chg;
        logic              par;
        op  = decode_op(ins);
        v   = op.dbl ? {e, a} : {a, 16'h0000};
        sgn = v[31];
        chg = 1'b0;
        par = 1'b0;
        for (int i = 0; i < scu_pkg::CNT_STEPS; i++) begin
            if (i < int'(op.cnt)) begin
                if (op.left) begin
                    par = par ^ v[31];
                    if (op.circ && op.dbl) begin
                        v = {v[30:0], v[31]};
                    end else if (op.circ) begin
                        v = {v[30:16], v[31], 16'h0000};
                    end else begin
                        v = {v[30:0], 1'b0};
                    end
                end else begin
                    if (op.circ && op.dbl) begin
                        v = {v[0], v[31:1]};
                    end else if (op.circ) begin
                        v = {v[16], v[31:17], 16'h0000};
                    end else if (op.dbl) begin
                        v = {v[31], v[31:1]};
                    end else begin
                        v = {v[31], v[31:17], 16'h0000};
                    end
                end
                chg = chg | (v[31] != sgn);
            end
        end
        r.ext   = op.dbl ? v[31:16] : e;
        r.acc   = op.dbl ? v[15:0] : v[31:16];
        r.ovfl  = op.left & ~op.circ & chg;
        r.carry = op.left & par;
        return r;
    endfunction : do_shift

    // ========================================================================
    // Bus slave
    // ========================================================================

    logic        dp_wr_ff;      // Write data phase pending
    logic        dp_rd_ff;      // Read data phase pending
    logic [7:0]  dp_addr_ff;    // Offset of the pending transfer
    logic [15:0] acc_ff;
    logic [15:0] ext_ff;
    logic        ovfl_ff;
    logic        carry_ff;
    logic        addr_take;
    logic        shift_go;
    logic        cmp_go;
    logic [15:0] wdat;
    scu_pkg::scu_res_t shift_res;
    scu_pkg::scu_res_t cmp_res;

    // Address phase is accepted on a selected NONSEQ while the bus is ready
    assign addr_take = hsel && hready && (htrans == scu_pkg::HTRANS_NONSEQ);
    assign wdat      = hwdata[15:0];
    assign shift_go  = dp_wr_ff && (dp_addr_ff == scu_pkg::OFS_SHIFT);
    assign cmp_go    = dp_wr_ff && (dp_addr_ff == scu_pkg::OFS_CMP);
    assign hreadyout = 1'b1;
    assign hresp     = scu_pkg::HRESP_OKAY;

    // Capture the address phase
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dp_wr_ff   <= 1'b0;
            dp_rd_ff   <= 1'b0;
            dp_addr_ff <= 8'h00;
        end else begin
            dp_wr_ff   <= addr_take && hwrite;
            dp_rd_ff   <= addr_take && !hwrite;
            dp_addr_ff <= addr_take ? haddr[7:0] : dp_addr_ff;
        end
    end

    // Read data from the stored state; unmapped offsets read zero
    always_comb begin
        hrdata = 32'h0000_0000;
        if (dp_rd_ff) begin
            case (dp_addr_ff)
                scu_pkg::OFS_ACC:   hrdata = {16'h0000, acc_ff};
                scu_pkg::OFS_EXT:   hrdata = {16'h0000, ext_ff};
                scu_pkg::OFS_FLAGS: hrdata = {30'h0000_0000, ovfl_ff, carry_ff};
                default:            hrdata = 32'h0000_0000;
            endcase
        end
    end

    // ========================================================================
    // Datapath
    // ========================================================================

    assign shift_res = do_shift(ext_ff, acc_ff, wdat);

    // Signed compare leaves both operands as they are
    always_comb begin
        cmp_res       = '0;
        cmp_res.ext   = ext_ff;
        cmp_res.acc   = acc_ff;
        cmp_res.ovfl  = ($signed(acc_ff) >= $signed(wdat));
        cmp_res.carry = (acc_ff == wdat);
    end

    // Accumulator pair; normalize encodings are not handled and change nothing
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            acc_ff <= scu_pkg::RST_ACC;
            ext_ff <= scu_pkg::RST_EXT;
        end else if (shift_go && !wdat[scu_pkg::BIT_NORM]) begin
            acc_ff <= shift_res.acc;
            ext_ff <= shift_res.ext;
        end else if (dp_wr_ff && dp_addr_ff == scu_pkg::OFS_ACC) begin
            acc_ff <= wdat;
        end else if (dp_wr_ff && dp_addr_ff == scu_pkg::OFS_EXT) begin
            ext_ff <= wdat;
        end
    end

    // Overflow and carry indicators
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ovfl_ff  <= scu_pkg::RST_FLAG;
            carry_ff <= scu_pkg::RST_FLAG;
        end else if (shift_go && !wdat[scu_pkg::BIT_NORM]) begin
            ovfl_ff  <= shift_res.ovfl;
            carry_ff <= shift_res.carry;
        end else if (cmp_go) begin
            ovfl_ff  <= cmp_res.ovfl;
            carry_ff <= cmp_res.carry;
        end else if (dp_wr_ff && dp_addr_ff == scu_pkg::OFS_FLAGS) begin
            ovfl_ff  <= hwdata[scu_pkg::FLG_OVFL];
            carry_ff <= hwdata[scu_pkg::FLG_CARRY];
        end
    end

    assign ovfl  = ovfl_ff;
    assign carry = carry_ff;

    // ========================================================================
    // Assertions
    // ========================================================================

    logic [15:0] p_acc_ff;      // State and write data one cycle back
    logic [15:0] p_ext_ff;
    logic [15:0] p_wd_ff;
    logic        p_go_ff;
    logic        p_cmp_ff;
    logic [4:0]  p_cnt;
    logic [31:0] h_rr;
    logic [31:0] h_ard;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            p_acc_ff <= 16'h0000;
            p_ext_ff <= 16'h0000;
            p_wd_ff  <= 16'h0000;
            p_go_ff  <= 1'b0;
            p_cmp_ff <= 1'b0;
        end else begin
            p_acc_ff <= acc_ff;
            p_ext_ff <= ext_ff;
            p_wd_ff  <= wdat;
            p_go_ff  <= shift_go && !wdat[scu_pkg::BIT_NORM];
            p_cmp_ff <= cmp_go;
        end
    end

    assign p_cnt = p_wd_ff[scu_pkg::CNT_MSB:0];
    assign h_rr  = {p_acc_ff, p_acc_ff} >> p_cnt[3:0];
    assign h_ard = 32'($signed({p_ext_ff, p_acc_ff}) >>> p_cnt);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    property p_right_flags;
        p_go_ff && !p_wd_ff[scu_pkg::BIT_LEFT] |-> !ovfl_ff && !carry_ff;
    endproperty
    a_right_flags: assert property (p_right_flags)
        else $error("right shift left an indicator set");

    property p_ars;
        p_go_ff && p_wd_ff[7:5] == 3'h0 |-> acc_ff == 16'($signed(p_acc_ff) >>> p_cnt);
    endproperty
    a_ars: assert property (p_ars)
        else $error("arithmetic right single result wrong");

    property p_als;
        p_go_ff && p_wd_ff[7:5] == 3'h1 |-> acc_ff == 16'(p_acc_ff << p_cnt);
    endproperty
    a_als: assert property (p_als)
        else $error("arithmetic left single result wrong");

    property p_rrs;
        p_go_ff && p_wd_ff[7:5] == 3'h2 |-> acc_ff == h_rr[15:0] && ext_ff == p_ext_ff;
    endproperty
    a_rrs: assert property (p_rrs)
        else $error("rotate right single result wrong");

    property p_ard;
        p_go_ff && p_wd_ff[7:5] == 3'h4 |-> {ext_ff, acc_ff} == h_ard;
    endproperty
    a_ard: assert property (p_ard)
        else $error("arithmetic right double result wrong");

    property p_ald;
        p_go_ff && p_wd_ff[7:5] == 3'h5 |->
            {ext_ff, acc_ff} == 32'({p_ext_ff, p_acc_ff} << p_cnt);
    endproperty
    a_ald: assert property (p_ald)
        else $error("arithmetic left double result wrong");

    property p_rot_left_ov;
        p_go_ff && p_wd_ff[6:5] == 2'h3 |-> !ovfl_ff;
    endproperty
    a_rot_left_ov: assert property (p_rot_left_ov)
        else $error("rotate left set overflow");

    property p_cmp_flags;
        p_cmp_ff |-> ovfl_ff == ($signed(p_acc_ff) >= $signed(p_wd_ff))
                     && carry_ff == (p_acc_ff == p_wd_ff);
    endproperty
    a_cmp_flags: assert property (p_cmp_flags)
        else $error("compare indicators wrong");

    property p_cmp_keep;
        p_cmp_ff |-> acc_ff == p_acc_ff && ext_ff == p_ext_ff;
    endproperty
    a_cmp_keep: assert property (p_cmp_keep)
        else $error("compare changed an operand");

    property p_zero_cnt;
        p_go_ff && p_cnt == 5'h00 |-> acc_ff == p_acc_ff && ext_ff == p_ext_ff
                                      && !ovfl_ff && !carry_ff;
    endproperty
    a_zero_cnt: assert property (p_zero_cnt)
        else $error("zero count changed state");

    property p_norm_keep;
        shift_go && wdat[scu_pkg::BIT_NORM] |=> $stable(acc_ff) && $stable(ext_ff);
    endproperty
    a_norm_keep: assert property (p_norm_keep)
        else $error("normalize encoding changed state");

    cover property (p_go_ff && p_wd_ff[7:5] == 3'h7 && carry_ff);
    cover property (p_go_ff && p_wd_ff[7:5] == 3'h1 && ovfl_ff);
    cover property (p_cmp_ff && ovfl_ff && carry_ff);
    cover property (p_go_ff && p_cnt == 5'h1f && p_wd_ff[scu_pkg::BIT_DOUBLE]);

endmodule : scu_top

`default_nettype wire

// file: testbench/shift_compare_unit_tb.sv
// Self-checking bench for the shift and compare unit over its AHB-Lite port
// Assumes scu_top is a zero wait slave on mclk with hready tied to hreadyout

`timescale 1ns/1ps
`default_nettype none

module shift_compare_unit_tb;

    // ========================================================================
    // Signals and bench state
    // ========================================================================
    logic        mclk;
    logic        nrst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        ovfl;
    logic        carry;
    logic [34:0] exp_q[$];
    logic        rd_pend = 1'b0;
    logic [31:0] lfsr;
    logic [15:0] e_m;
    logic [15:0] a_m;
    logic        o_m;
    logic        c_m;
    int          err_count;
    int          checks_done;
    int          cycles;
    logic [4:0]  cnt_tab[6] = '{5'h00, 5'h01, 5'h0f, 5'h10, 5'h11, 5'h1f};
    logic [31:0] cmp_tab[5] = '{32'h80007fff, 32'h7fff8000, 32'h12341234,
                                32'hffff0001, 32'h0001ffff};

    // ========================================================================
    // Device, clock and ready loop
    // ========================================================================
    scu_top DUT (
        .mclk      (mclk),
        .nrst      (nrst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .ovfl      (ovfl),
        .carry     (carry)
    );

    assign hready = hreadyout;

    initial mclk = 1'b0;
    always #20 mclk = ~mclk;

    // ========================================================================
    // Helpers
    // ========================================================================
    // Stir the random source a full word at a time
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        for (int i = 0; i < 32; i++) begin
            s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        end
        return s;
    endfunction : lfsr_next

    // Reference shift: returns ext, acc, overflow, carry
    function automatic logic [33:0] ref_shift(input logic [15:0] e, input logic [15:0] a,
                                              input logic [8:0] ins, input logic o,
                                              input logic c);
        logic [31:0] v;
        logic [31:0] msk;
        logic        sgn;
        logic        b;
        logic        ov;
        logic        par;
        int          top;
        if (ins[8]) begin
            return {e, a, o, c};
        end
        top = ins[7] ? 31 : 15;
        msk = ins[7] ? 32'hffffffff : 32'h0000ffff;
        v   = ins[7] ? {e, a} : {16'h0000, a};
        sgn = v[top];
        ov  = 1'b0;
        par = 1'b0;
        for (int i = 0; i < int'(ins[4:0]); i++) begin
            if (ins[5]) begin
                b   = v[top];
                par = par ^ b;
                v   = ((v << 1) | (ins[6] ? {31'h0, b} : 32'h0)) & msk;
                ov  = ov | (v[top] != sgn);
            end else begin
                b      = ins[6] ? v[0] : v[top];
                v      = v >> 1;
                v[top] = b;
            end
        end
        if (!ins[7]) begin
            v[31:16] = e;
        end
        return {v, ins[5] & ~ins[6] & ov, ins[5] & par};
    endfunction : ref_shift

    // Compare one seen value with one expected value
    task automatic check(input logic [34:0] seen, input logic [34:0] want);
        checks_done++;
        if (seen !== want) begin
            err_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check

    // Print the verdict and stop
    task automatic tally_and_finish;
        if (err_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    // One single AHB-Lite transfer, entered just after a rising edge
    task automatic ahb_xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, ofs};
        htrans <= scu_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : ~d;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
    endtask : ahb_xfer

    // Read with the expected response, indicators and data noted first
    task automatic rd(input logic [7:0] ofs, input logic [31:0] want);
        exp_q.push_back({scu_pkg::HRESP_OKAY, o_m, c_m, want});
        ahb_xfer(1'b0, ofs, 32'h00000000);
    endtask : rd

    // Random operands, one shift, then both registers read back
    task automatic shift_case(input logic [8:0] ins);
        lfsr = lfsr_next(lfsr);
        e_m  = lfsr[31:16];
        a_m  = lfsr[15:0];
        ahb_xfer(1'b1, scu_pkg::OFS_EXT, {16'h0000, e_m});
        ahb_xfer(1'b1, scu_pkg::OFS_ACC, {16'h0000, a_m});
        ahb_xfer(1'b1, scu_pkg::OFS_SHIFT, {23'h000000, ins});
        {e_m, a_m, o_m, c_m} = ref_shift(e_m, a_m, ins, o_m, c_m);
        rd(scu_pkg::OFS_ACC, {16'h0000, a_m});
        rd(scu_pkg::OFS_EXT, {16'h0000, e_m});
    endtask : shift_case

    // Signed compare of the accumulator with a word
    task automatic cmp_case(input logic [15:0] a, input logic [15:0] w);
        a_m = a;
        ahb_xfer(1'b1, scu_pkg::OFS_ACC, {16'h0000, a});
        ahb_xfer(1'b1, scu_pkg::OFS_CMP, {16'h0000, w});
        o_m = $signed(a) >= $signed(w);
        c_m = a == w;
        rd(scu_pkg::OFS_ACC, {16'h0000, a_m});
        rd(scu_pkg::OFS_FLAGS, {30'h0, o_m, c_m});
    endtask : cmp_case

    // ========================================================================
    // Monitor: pop the oldest note at each read data phase end
    // ========================================================================
    always @(posedge mclk) begin
        if (rd_pend) begin
            check({hresp, ovfl, carry, hrdata}, exp_q.pop_front());
        end
        rd_pend <= nrst && hsel && htrans == scu_pkg::HTRANS_NONSEQ && !hwrite && hready;
    end

    // Timeout guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            tally_and_finish();
        end
    end

    // ========================================================================
    // Main sequence
    // ========================================================================
    initial begin
        nrst = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        lfsr = 32'hf0ab44ac;
        e_m = scu_pkg::RST_EXT;
        a_m = scu_pkg::RST_ACC;
        o_m = scu_pkg::RST_FLAG;
        c_m = scu_pkg::RST_FLAG;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        // Reset values, unmapped place, flag register read and write
        rd(scu_pkg::OFS_ACC, 32'h0);
        rd(scu_pkg::OFS_EXT, 32'h0);
        rd(scu_pkg::OFS_FLAGS, 32'h0);
        ahb_xfer(1'b1, 8'h14, 32'hffffffff);
        rd(8'h14, 32'h0);
        ahb_xfer(1'b1, scu_pkg::OFS_FLAGS, 32'h00000003);
        o_m = 1'b1;
        c_m = 1'b1;
        rd(scu_pkg::OFS_FLAGS, 32'h00000003);
        // Normalize is refused with no change
        shift_case(9'h105);
        // Every shift code at boundary and random counts
        for (int k = 0; k < 8; k++) begin
            foreach (cnt_tab[j]) begin
                shift_case({1'b0, 3'(k), cnt_tab[j]});
            end
            shift_case({1'b0, 3'(k), lfsr[4:0]});
            shift_case({1'b0, 3'(k), lfsr[9:5]});
        end
        // Compare boundaries and random pairs
        foreach (cmp_tab[j]) begin
            cmp_case(cmp_tab[j][31:16], cmp_tab[j][15:0]);
        end
        for (int k = 0; k < 8; k++) begin
            lfsr = lfsr_next(lfsr);
            cmp_case(lfsr[31:16], lfsr[15:0]);
        end
        rd(scu_pkg::OFS_EXT, {16'h0000, e_m});
        @(posedge mclk);
        tally_and_finish();
    end

endmodule : shift_compare_unit_tb

`default_nettype wire
